// ### bench/sts_peer.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Serial peer: drives on the falling clock, samples on the rising clock
// ****************************************
module sts_peer (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Bench control
  input wire logic arm_i,
  input wire logic [7:0] tx_i,
  input wire logic start_i,
  // Serial lines
  input wire logic sck_i,
  input wire logic sdo_i,
  output logic sdi_o,
  output logic [7:0] rx_o
);
  logic sck_q;
  logic [7:0] tx_r;
  logic [2:0] idx_r;
  logic [5:0] idle_r;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sck_q <= 1'b1;
      tx_r <= 8'hFF;
      idx_r <= 3'h7;
      idle_r <= 6'h00;
      sdi_o <= 1'b1;
      rx_o <= 8'h00;
    end else begin
      sck_q <= sck_i;
      if (sck_q != sck_i || arm_i || start_i) begin
        idle_r <= 6'h00;
      end else if (idle_r != 6'h3F) begin
        idle_r <= idle_r + 6'h01;
      end
      if (arm_i) begin
        tx_r <= tx_i;
        idx_r <= 3'h7;
        sdi_o <= tx_i[7];
      end else if (start_i) begin
        sdi_o <= 1'b0;
      end else if (sck_q && !sck_i) begin
        sdi_o <= tx_r[idx_r];
      end else if (!sck_q && sck_i) begin
        rx_o <= {rx_o[6:0], sdo_i};
        idx_r <= idx_r - 3'h1;
      end else if (idle_r == 6'h30) begin
        // Released line returns to its pull-up level after 48 idle cycles; until then it keeps the last bit
        sdi_o <= 1'b1;
      end
    end
  end
endmodule // sts_peer
`default_nettype wire

// ### bench/sts_port_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module sts_port_test;
  localparam int TICK_P = 40;
  logic clk, rstn, awvalid, wvalid, bready, arvalid, rready, arm, start;
  logic awready, wready, bvalid, arready, rvalid, busy, irq;
  logic sck_o, sck_oe, sdo_o, sdo_oe, sdi, sck_w, sdo_w;
  logic tick = 1'b0;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [7:0] ptx, prx, d, pd;
  logic [7:0] seed = 8'h46;
  logic [33:0] mon_got;
  logic [33:0] exp_q[$];
  logic [33:0] msk_q[$];
  int miscompares = 0, checks_done = 0, irq_cnt = 0, busy_cnt = 0, tcnt = 0;
  int hv[4] = '{int'(sts_pkg::HALF_DIV2), int'(sts_pkg::HALF_DIV8),
    int'(sts_pkg::HALF_DIV64), TICK_P};

  // Both lines carry pull-ups
  assign sck_w = sck_oe ? sck_o : 1'b1;
  assign sdo_w = sdo_oe ? sdo_o : 1'b1;

  sts_port uut (
    .mclk_i(clk), .rstn_i(rstn),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .timer3_tick_i(tick),
    .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o),
    .serial_clock_pin_oe_o(sck_oe), .serial_data_in_pin_i(sdi),
    .serial_data_out_pin_o(sdo_o), .serial_data_out_pin_oe_o(sdo_oe),
    .transfer_busy_flag_o(busy), .transfer_done_irq_o(irq)
  );

  sts_peer peer (
    .mclk_i(clk), .rstn_i(rstn), .arm_i(arm), .tx_i(ptx),
    .start_i(start), .sck_i(sck_w), .sdo_i(sdo_w), .sdi_o(sdi),
    .rx_o(prx)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ****************************************
  // Watchers
  // ****************************************
  always @(posedge clk) begin
    tcnt <= (tcnt == TICK_P - 1) ? 0 : tcnt + 1;
    tick <= (tcnt == TICK_P - 1);
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (busy === 1'b1) busy_cnt <= busy_cnt + 1;
    if (exp_q.size() > 0 && ((bvalid && bready) || (rvalid && rready))) begin
      mon_got = bvalid ? {bresp, 32'h0} : {rresp, rdata};
      `CHK(mon_got & msk_q[0], exp_q[0] & msk_q[0])
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    give_verdict();
  end

  // ****************************************
  // Tasks
  // ****************************************
  function automatic logic [7:0] rnd();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction

  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev8[i] = v[7-i];
  endfunction

  task automatic wr(input logic [15:0] a, input logic [7:0] v,
                    input logic [1:0] rsp);
    logic aw_p, w_p;
    exp_q.push_back({rsp, 32'h0});
    msk_q.push_back({34{1'b1}});
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    while (aw_p || w_p) begin
      @(posedge clk);
      if (aw_p && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [1:0] rsp,
                    input logic [7:0] v, input logic [7:0] m);
    exp_q.push_back({rsp, 24'h000000, v});
    msk_q.push_back({26'h3FFFFFF, m});
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  task automatic setup(input logic [7:0] ma, input logic [1:0] cks);
    wr(sts_pkg::ADR_MODE_B, 8'h00, sts_pkg::RESP_OKAY);
    wr(sts_pkg::ADR_MODE_A, ma, sts_pkg::RESP_OKAY);
    wr(sts_pkg::ADR_MODE_B, {6'h01, cks}, sts_pkg::RESP_OKAY);
    wr(sts_pkg::ADR_MODE_B, {6'h03, cks}, sts_pkg::RESP_OKAY);
    wr(sts_pkg::ADR_MODE_B, {6'h07, cks}, sts_pkg::RESP_OKAY);
  endtask

  task automatic frame(input logic [7:0] pexp, input logic [7:0] m,
                       input int nb, input int half);
    int i0, b0, bc;
    ptx <= pd;
    arm <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
    i0 = irq_cnt;
    b0 = busy_cnt;
    wr(sts_pkg::ADR_DATA, d, sts_pkg::RESP_OKAY);
    `CHK(busy, 1'b1)
    do @(posedge clk); while (irq !== 1'b1);
    repeat (3) @(posedge clk);
    `CHK(irq_cnt - i0, 32'h1)
    `CHK(busy, 1'b0)
    `CHK(prx & m, pexp & m)
    bc = busy_cnt - b0;
    `CHK((bc >= (2*nb-1)*half) && (bc <= (2*nb+1)*half+2), 1'b1)
  endtask

  task automatic give_verdict();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rstn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, arm, start} = 7'h00;
    awaddr = 16'h0000;
    araddr = 16'h0000;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    ptx = 8'h00;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK({sck_oe, sdo_oe, busy}, 3'h0)
    rd(sts_pkg::ADR_MODE_A, sts_pkg::RESP_OKAY, 8'h00, 8'hFF);
    rd(sts_pkg::ADR_MODE_B, sts_pkg::RESP_OKAY, 8'h00, 8'hFF);
    rd(sts_pkg::ADR_DATA, sts_pkg::RESP_OKAY, 8'h00, 8'hFF);
    rd(16'hFD68, sts_pkg::RESP_SLVERR, 8'h00, 8'hFF);
    wr(16'hFD68, 8'h5A, sts_pkg::RESP_SLVERR);
    // Received data is only judged on slow sources: the input sampler
    // needs three cycles of settled data before each sampling edge
    for (int s = 0; s < 4; s++) begin
      setup(8'h00, s[1:0]);
      d = rnd();
      pd = rnd();
      frame(d, 8'hFF, 8, hv[s]);
      `CHK(sdo_w, d[0])
      if (hv[s] >= 32) rd(sts_pkg::ADR_DATA, sts_pkg::RESP_OKAY, pd, 8'hFF);
    end
    wr(sts_pkg::ADR_MODE_A, 8'h60, sts_pkg::RESP_OKAY);
    rd(sts_pkg::ADR_MODE_A, sts_pkg::RESP_OKAY, 8'h00, 8'hFF);
    setup(8'h10, 2'h2);
    d = rnd();
    pd = rnd();
    frame(rev8(d), 8'hFF, 8, 32);
    rd(sts_pkg::ADR_DATA, sts_pkg::RESP_OKAY, rev8(pd), 8'hFF);
    setup(8'h05, 2'h2);
    d = rnd();
    pd = rnd();
    frame({3'h0, d[7:3]}, 8'h1F, 5, 32);
    rd(sts_pkg::ADR_DATA, sts_pkg::RESP_OKAY, {3'h0, pd[7:3]}, 8'h1F);
    rd(sts_pkg::ADR_MODE_A, sts_pkg::RESP_OKAY, 8'h02, 8'h07);
    setup(8'h0B, 2'h2);
    // Top bit kept high: arming the peer must not itself fake a start
    pd = rnd() | 8'h80;
    ptx <= pd;
    arm <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
    repeat (60) @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    do @(posedge clk); while (irq !== 1'b1);
    @(posedge clk);
    `CHK(sdo_w, 1'b1)
    rd(sts_pkg::ADR_DATA, sts_pkg::RESP_OKAY, pd, 8'hFF);
    rd(sts_pkg::ADR_MODE_A, sts_pkg::RESP_OKAY, 8'h08, 8'hFF);
    give_verdict();
  end
endmodule // sts_port_test
`default_nettype wire

// ### core/sts_pkg.sv
package sts_pkg;

  // ****************************************
  // Register map (printed index, byte = 4 x index)
  // ****************************************
  localparam int unsigned ADDR_W = 16;
  localparam logic [15:0] IDX_MODE_A = 16'h3F57;
  localparam logic [15:0] IDX_MODE_B = 16'h3F58;
  localparam logic [15:0] IDX_DATA = 16'h3F59;
  localparam logic [15:0] ADR_MODE_A = {IDX_MODE_A[13:0], 2'b00};
  localparam logic [15:0] ADR_MODE_B = {IDX_MODE_B[13:0], 2'b00};
  localparam logic [15:0] ADR_DATA = {IDX_DATA[13:0], 2'b00};
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Field layouts and reset values
  // ****************************************
  typedef struct packed {
    logic busy;
    logic ce0;
    logic ce1;
    logic dir;
    logic ste;
    logic [2:0] lng;
  } sts_mode_a_s;

  typedef struct packed {
    logic slave;
    logic sbom;
    logic sbtm;
    logic doe;
    logic die;
    logic cpe;
    logic [1:0] cks;
  } sts_mode_b_s;

  localparam logic [7:0] MODE_A_RST = 8'h00;
  localparam logic [7:0] MODE_B_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // ****************************************
  // Clock source and timing counts
  // ****************************************
  typedef enum logic [1:0] {
    CKS_DIV2, CKS_DIV8, CKS_DIV64, CKS_TMR3
  } sts_cks_e;

  localparam logic [5:0] HALF_DIV2 = 6'h01;
  localparam logic [5:0] HALF_DIV8 = 6'h04;
  localparam logic [5:0] HALF_DIV64 = 6'h20;
  localparam logic [3:0] FULL_FRAME = 4'h8;

  typedef struct packed {
    logic sck;
    logic sdi;
  } sts_pins_s;

endpackage

// ### core/sts_port.sv
`timescale 1ns/10ps
`default_nettype none
module sts_port (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // AXI4-Lite slave
  input wire logic [sts_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [sts_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Timer 3 output, one-cycle pulse on mclk_i
  input wire logic timer3_tick_i,
  // Serial pins
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_o,
  input wire logic serial_data_in_pin_i,
  output logic serial_data_out_pin_o,
  output logic serial_data_out_pin_oe_o,
  // Status
  output logic transfer_busy_flag_o,
  output logic transfer_done_irq_o
);

  // ****************************************
  // Declarations
  // ****************************************
  typedef enum {ST_IDLE, ST_RUN, ST_TAIL} sts_state_e;

  sts_state_e st_r;
  sts_pkg::sts_mode_a_s ma_r;
  sts_pkg::sts_mode_b_s mb_r;
  sts_pkg::sts_mode_a_s wa;
  sts_pkg::sts_mode_b_s wb;
  sts_pkg::sts_pins_s s2, s3, pin_r, pin_nxt;
  logic [7:0] shreg_r, wd, wval;
  logic [3:0] cnt_r, nbits, left;
  logic [5:0] div_r, half;
  logic busy_r, irq_r, sdo_r, sck_r;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [sts_pkg::ADDR_W-1:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wstrb_r, wr_go, wr_a, wr_b, wr_data;
  logic en, master, tick, rise, fall, run;
  logic out_edge, smp_edge, lng_edge, sdi_v, sck_lvl;
  logic start_det, m_act, done;
  logic sck_o_r, sck_oe_r, sdo_o_r, sdo_oe_r;

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= sts_pkg::RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= 8'h00;
      wstrb_r <= 1'b0;
    end else begin
      if (s_axi_awvalid_i && awready_r) begin
        awaddr_r <= s_axi_awaddr_i;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid_i && wready_r) begin
        wdata_r <= s_axi_wdata_i[7:0];
        wstrb_r <= s_axi_wstrb_i[0];
        wready_r <= 1'b0;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= (wr_a | wr_b | (awaddr_r == sts_pkg::ADR_DATA)) ?
                   sts_pkg::RESP_OKAY : sts_pkg::RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready_i) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  assign wr_go = ~awready_r & ~wready_r & ~bvalid_r;
  assign wr_a = wr_go & (awaddr_r == sts_pkg::ADR_MODE_A);
  assign wr_b = wr_go & (awaddr_r == sts_pkg::ADR_MODE_B);
  assign wr_data = wr_go & wstrb_r & (awaddr_r == sts_pkg::ADR_DATA);
  assign wd = wdata_r;
  assign wa = wdata_r;
  assign wb = wdata_r;
  // Reversal path sits in front of the shift register for LSB first
  assign wval = ma_r.dir ? rev8(wd) : wd;

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= sts_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= sts_pkg::RESP_OKAY;
      case (s_axi_araddr_i)
        sts_pkg::ADR_MODE_A: begin
          rdata_r <= {24'h000000, busy_r, ma_r[6:0]};
        end
        sts_pkg::ADR_MODE_B: begin
          rdata_r <= {24'h000000, mb_r};
        end
        sts_pkg::ADR_DATA: begin
          rdata_r <= {24'h000000,
                      ma_r.dir ? rev8(shreg_r) : shreg_r};
        end
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= sts_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready_i) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o = wready_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;

  // ****************************************
  // Pin synchronisers and edge detection
  // ****************************************
  sts_sync3 #(.W($bits(sts_pkg::sts_pins_s))) u_sync (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .d_i({serial_clock_pin_i, serial_data_in_pin_i}),
    .q2_o(s2),
    .q3_o(s3)
  );

  // A pin level only counts once the second and third stages agree
  always_comb begin
    pin_nxt = pin_r;
    if (s2.sck == s3.sck) pin_nxt.sck = s3.sck;
    if (s2.sdi == s3.sdi) pin_nxt.sdi = s3.sdi;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_r <= '1;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  assign en = mb_r.doe | mb_r.die;
  assign master = ~mb_r.slave;
  assign sdi_v = mb_r.die ? pin_nxt.sdi : 1'b1;
  assign sck_lvl = master ? sck_r : pin_nxt.sck;
  assign rise = master ? (tick & ~sck_r & (st_r == ST_RUN))
                       : (pin_nxt.sck & ~pin_r.sck);
  assign fall = master ? (tick & sck_r & (st_r == ST_RUN))
                       : (~pin_nxt.sck & pin_r.sck);
  // A slave listens whenever enabled; a master only inside its frame
  assign run = en & (busy_r | ~master);
  assign out_edge = run & (ma_r.ce1 ? rise : fall);
  assign lng_edge = run & (ma_r.ce1 ? fall : rise);
  assign smp_edge = ma_r.ce0 ? out_edge : lng_edge;
  assign start_det = en & ma_r.ste & mb_r.die & ~busy_r & pin_r.sdi &
                     ~pin_nxt.sdi & (ma_r.ce1 | sck_lvl);
  assign m_act = master & en & ~busy_r & wr_data;
  assign nbits = (ma_r.lng == 3'h0) ? sts_pkg::FULL_FRAME
                                    : {1'b0, ma_r.lng};
  assign left = busy_r ? cnt_r : nbits;
  assign done = smp_edge & (left == 4'h1);

  // ****************************************
  // Mode registers
  // ****************************************
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ma_r <= sts_pkg::MODE_A_RST;
    end else begin
      if (wr_a && wstrb_r) begin
        ma_r.lng <= wa.lng;
        ma_r.ste <= wa.ste;
        ma_r.dir <= wa.dir;
        // Locked while enabled so the live counter cannot slip
        if (!en) begin
          ma_r.ce1 <= wa.ce1;
          ma_r.ce0 <= wa.ce0;
        end
      end
      if (start_det) begin
        ma_r.lng <= 3'h0;
      end else if (lng_edge) begin
        ma_r.lng <= ma_r.lng + 3'h1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mb_r <= sts_pkg::MODE_B_RST;
    end else if (wr_b && wstrb_r) begin
      mb_r <= wb;
    end
  end

  // ****************************************
  // Frame control
  // ****************************************
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      irq_r <= 1'b0;
    end else begin
      irq_r <= done;
      if (!en) begin
        busy_r <= 1'b0;
      end else if (start_det) begin
        busy_r <= 1'b1;
        cnt_r <= sts_pkg::FULL_FRAME;
      end else if (m_act) begin
        busy_r <= 1'b1;
        cnt_r <= nbits;
      end else if (smp_edge) begin
        busy_r <= ~done;
        cnt_r <= left - 4'h1;
      end
    end
  end

  assign transfer_busy_flag_o = busy_r;
  assign transfer_done_irq_o = irq_r;

  AST_BUSY_CLR: assert property (done |=> !busy_r && irq_r)
    else $error("busy not cleared with done pulse");
  AST_IRQ_ONCE: assert property (irq_r |=> !irq_r)
    else $error("done pulse longer than one cycle");
  AST_MST_ACT: assert property (m_act |=> busy_r && cnt_r == $past(nbits))
    else $error("master write did not start a frame");
  AST_LEN8: assert property (m_act && ma_r.lng == 3'h0 |=> cnt_r == 4'h8)
    else $error("length 000 is not eight bits");
  AST_START: assert property (start_det |=> ma_r.lng == 3'h0 && busy_r)
    else $error("start did not clear length");
  AST_IDLE: assert property (!en |=> !busy_r)
    else $error("busy while port disabled");

  // ****************************************
  // Shift register and data out
  // ****************************************
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shreg_r <= sts_pkg::DATA_RST;
    end else if (wr_data && !busy_r) begin
      shreg_r <= wval;
    end else if (smp_edge) begin
      shreg_r <= {shreg_r[6:0], sdi_v};
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sdo_r <= 1'b1;
    end else if (!mb_r.doe) begin
      sdo_r <= 1'b1;
    end else if (m_act) begin
      sdo_r <= wval[7];
    end else if (!master && wr_data && !busy_r) begin
      sdo_r <= 1'b0;
    end else if (done && ma_r.ste) begin
      sdo_r <= 1'b1;
    end else if (out_edge) begin
      // Same edge sampling shifts now, so the next bit is bit 6
      sdo_r <= ma_r.ce0 ? shreg_r[6] : shreg_r[7];
    end
  end

  AST_SDO_HI: assert property (done && ma_r.ste && mb_r.doe |=> sdo_r)
    else $error("data out not high after frame");
  AST_CE_LOCK: assert property (wr_a && en |=>
      ma_r.ce1 == $past(ma_r.ce1) && ma_r.ce0 == $past(ma_r.ce0))
    else $error("edge bits changed while enabled");

  // ****************************************
  // Master clock generator
  // ****************************************
  always_comb begin
    case (sts_pkg::sts_cks_e'(mb_r.cks))
      sts_pkg::CKS_DIV2: half = sts_pkg::HALF_DIV2;
      sts_pkg::CKS_DIV8: half = sts_pkg::HALF_DIV8;
      sts_pkg::CKS_DIV64: half = sts_pkg::HALF_DIV64;
      default: half = sts_pkg::HALF_DIV2;
    endcase
  end

  assign tick = (mb_r.cks == sts_pkg::CKS_TMR3) ? timer3_tick_i
                : (div_r == half - 6'h01);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_r <= 6'h00;
    end else if (st_r == ST_IDLE || tick) begin
      div_r <= 6'h00;
    end else begin
      div_r <= div_r + 6'h01;
    end
  end

  // Clock idles high; a frame ending low gets one more half period
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= ST_IDLE;
      sck_r <= 1'b1;
    end else if (!en || !master) begin
      st_r <= ST_IDLE;
      sck_r <= 1'b1;
    end else begin
      if (st_r != ST_IDLE && tick) sck_r <= ~sck_r;
      case (st_r)
        ST_IDLE: begin
          if (m_act || start_det) st_r <= ST_RUN;
        end
        ST_RUN: begin
          if (done) st_r <= sck_r ? ST_TAIL : ST_IDLE;
        end
        ST_TAIL: begin
          if (tick) st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  AST_CLK_IDLE: assert property (st_r == ST_IDLE |-> sck_r)
    else $error("master clock not idle high");

  // ****************************************
  // Pin drivers
  // ****************************************
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sck_o_r <= 1'b1;
      sck_oe_r <= 1'b0;
      sdo_o_r <= 1'b1;
      sdo_oe_r <= 1'b0;
    end else begin
      sck_o_r <= mb_r.sbtm ? 1'b0 : sck_r;
      sck_oe_r <= master & mb_r.cpe & (~mb_r.sbtm | ~sck_r);
      sdo_o_r <= mb_r.sbom ? 1'b0 : sdo_r;
      sdo_oe_r <= mb_r.doe & (~mb_r.sbom | ~sdo_r);
    end
  end

  assign serial_clock_pin_o = sck_o_r;
  assign serial_clock_pin_oe_o = sck_oe_r;
  assign serial_data_out_pin_o = sdo_o_r;
  assign serial_data_out_pin_oe_o = sdo_oe_r;

  AST_SDO_OFF: assert property (!mb_r.doe |=> !sdo_oe_r)
    else $error("data out driven while disabled");

  COV_MST_FRAME: cover property (m_act ##[1:600] irq_r);
  COV_START_RX: cover property (start_det ##[1:600] irq_r);
  COV_SLV_FRAME: cover property (!master && smp_edge && done);
endmodule // sts_port
`default_nettype wire

// ### core/sts_sync3.sv
`timescale 1ns/10ps
`default_nettype none
module sts_sync3 #(
  parameter int unsigned W = 2
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Asynchronous levels in, second and third stage out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q2_o,
  output logic [W-1:0] q3_o
);
  logic [W-1:0] q1_r;
  logic [W-1:0] q2_r;
  logic [W-1:0] q3_r;

  // Idle lines are high, so reset to ones to avoid a false edge
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q1_r <= '1;
      q2_r <= '1;
      q3_r <= '1;
    end else begin
      q1_r <= d_i;
      q2_r <= q1_r;
      q3_r <= q2_r;
    end
  end

  assign q2_o = q2_r;
  assign q3_o = q3_r;
endmodule // sts_sync3
`default_nettype wire
